//--- machine_cycle_status_sequencer_bench.sv
// Purpose: self-checking bench for the machine-cycle sequencer
// Assumes: phi1 and stateTick alternate, one clock each
// Notes: the halt cycle reads like any memory read cycle
module machine_cycle_status_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset_n = 0, phi1 = 0, stateTick = 0, instrValid = 0;
  logic clear = 0, slowMode = 0;
  mcss_pkg::mcss_instr_t instr = '0;
  logic instrReady, cycleSync, dataOutEn, data_bus_in_strobe, busy, ready;
  logic writeStrobe_n;
  logic [7:0] dataOut;
  logic [2:0] machineCycle, clockState;
  logic [3:0] latchCount, readCount, writeCount, holdErrors;
  logic [4:0] stateCount;
  logic [39:0] wordLog;
  int n_fail = 0;
  int num_checks = 0;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    #1;
    phi1 = ~phi1;
    stateTick = ~phi1;
  end
  mcss_sequencer dut_u (.clock(clock), .reset_n(reset_n), .phi1(phi1),
    .stateTick(stateTick), .ready(ready), .instrValid(instrValid),
    .instr(instr), .instrReady(instrReady), .cycleSync(cycleSync),
    .dataOut(dataOut), .dataOutEn(dataOutEn),
    .data_bus_in_strobe(data_bus_in_strobe), .writeStrobe_n(writeStrobe_n),
    .machineCycle(machineCycle), .clockState(clockState), .busy(busy));
  mcss_controller_model ctrl_u (.clock(clock), .reset_n(reset_n),
    .clear(clear), .slowMode(slowMode), .cycleSync(cycleSync),
    .dataOutEn(dataOutEn), .dataOut(dataOut),
    .data_bus_in_strobe(data_bus_in_strobe), .writeStrobe_n(writeStrobe_n),
    .clockState(clockState), .ready(ready), .latchCount(latchCount),
    .stateCount(stateCount), .readCount(readCount),
    .writeCount(writeCount), .holdErrors(holdErrors), .wordLog(wordLog));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // words packs the status of each cycle, last cycle in the low byte
  task automatic run(input mcss_pkg::mcss_class_t cls, input logic cond,
      input logic ack, input logic [3:0] nCyc, input logic [4:0] nSt,
      input logic [39:0] words);
    logic [3:0] nRd, nWr;
    logic [7:0] w;
    int i;
    nRd = 0;
    nWr = 0;
    for (i = 0; i < nCyc; i++) begin
      w = words[8*i +: 8];
      if (w[7] || w[6] || w[0]) nRd++;
      if (!w[3] && !w[1]) nWr++;
    end
    @(posedge clock);
    #1;
    clear = 1;
    instrValid = 1;
    instr = '{cls, cond, ack};
    i = 0;
    do begin @(posedge clock); i++; end while (instrReady !== 1'b1 && i < 20);
    #1;
    instrValid = 0;
    clear = 0;
    do begin @(posedge clock); i++; end while (busy !== 1'b0 && i < 600);
    if (i >= 600) begin
      n_fail++;
      wrap_up;
    end
    repeat (2) @(posedge clock);
    check(latchCount, nCyc);
    check(stateCount, nSt);
    check(wordLog, words);
    check(readCount, nRd);
    check(writeCount, nWr);
    check(holdErrors, 40'h0);
  endtask : run
  task automatic test_one_cycle;
    run(mcss_pkg::IC_SIMPLE4, 1'b1, 1'b0, 4'h1, 5'h04, 40'ha2);
    run(mcss_pkg::IC_REG5, 1'b1, 1'b0, 4'h1, 5'h05, 40'ha2);
    run(mcss_pkg::IC_HALT, 1'b1, 1'b0, 4'h1, 5'h04, 40'h8a);
    $display("test one_cycle done");
  endtask : test_one_cycle
  task automatic test_operand_reads;
    run(mcss_pkg::IC_IMM8, 1'b1, 1'b0, 4'h2, 5'h07, 40'ha282);
    run(mcss_pkg::IC_JUMP_LXI, 1'b1, 1'b0, 4'h3, 5'h0a,
      40'h00_00a2_8282);
    $display("test operand_reads done");
  endtask : test_operand_reads
  task automatic test_conditional;
    run(mcss_pkg::IC_CALL, 1'b1, 1'b0, 4'h5, 5'h11,
      40'ha2_8282_0404);
    run(mcss_pkg::IC_CALL, 1'b0, 1'b0, 4'h3, 5'h0b,
      40'h00_00a2_8282);
    run(mcss_pkg::IC_RET_COND, 1'b1, 1'b0, 4'h3, 5'h0b,
      40'h00_00a2_8686);
    run(mcss_pkg::IC_RET_COND, 1'b0, 1'b0, 4'h1, 5'h05, 40'ha2);
    $display("test conditional done");
  endtask : test_conditional
  task automatic test_execute;
    run(mcss_pkg::IC_DOUBLE_ADD, 1'b1, 1'b0, 4'h3, 5'h0a,
      40'h00_00a2_0202);
    run(mcss_pkg::IC_MEM_INCDEC, 1'b1, 1'b0, 4'h3, 5'h0a,
      40'h00_00a2_8200);
    run(mcss_pkg::IC_STORE_PTR_DIRECT, 1'b1, 1'b0, 4'h5, 5'h10,
      40'ha2_8282_0000);
    run(mcss_pkg::IC_OUT, 1'b1, 1'b0, 4'h3, 5'h0a,
      40'h00_00a2_8210);
    run(mcss_pkg::IC_IN, 1'b1, 1'b0, 4'h3, 5'h0a,
      40'h00_00a2_8242);
    $display("test execute done");
  endtask : test_execute
  task automatic test_int_ack;
    run(mcss_pkg::IC_SIMPLE4, 1'b1, 1'b1, 4'h1, 5'h04, 40'h23);
    $display("test int_ack done");
  endtask : test_int_ack
  task automatic test_wait_states;
    // waits stretch state two but must not add states
    slowMode = 1;
    run(mcss_pkg::IC_JUMP_LXI, 1'b1, 1'b0, 4'h3, 5'h0a,
      40'h00_00a2_8282);
    slowMode = 0;
    $display("test wait_states done");
  endtask : test_wait_states
  initial begin
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1;
    repeat (3) @(posedge clock);
    test_one_cycle;
    test_operand_reads;
    test_conditional;
    test_execute;
    test_int_ack;
    test_wait_states;
    wrap_up;
  end
endmodule : machine_cycle_status_sequencer_bench

//--- mcss_controller_model.sv
// Purpose: system controller model that latches status and paces ready
// Assumes: status is taken once per sync window while phase one is high
// Notes: counters clear on the bench's clear pulse, one instruction each
module mcss_controller_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bench control
  input wire logic clear,
  input wire logic slowMode,
  // sequencer side
  input wire logic cycleSync,
  input wire logic dataOutEn,
  input wire logic [7:0] dataOut,
  input wire logic data_bus_in_strobe,
  input wire logic writeStrobe_n,
  input wire logic [2:0] clockState,
  output logic ready,
  // observations
  output logic [3:0] latchCount,
  output logic [4:0] stateCount,
  output logic [3:0] readCount,
  output logic [3:0] writeCount,
  output logic [3:0] holdErrors,
  output logic [39:0] wordLog
);
  timeunit 1ns;
  timeprecision 1ns;
  logic taken, prevEn, prevIn, prevWr;
  logic [7:0] prevOut;
  logic [2:0] prevState;
  logic [1:0] waitCnt;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {taken, prevEn, prevIn, prevWr, prevOut, prevState} <= '0;
      {latchCount, stateCount, readCount, writeCount, holdErrors} <= '0;
      wordLog <= '0;
      waitCnt <= '0;
      ready <= 1'b1;
    end else begin
      prevEn <= dataOutEn;
      prevOut <= dataOut;
      prevState <= clockState;
      prevIn <= data_bus_in_strobe;
      prevWr <= writeStrobe_n;
      taken <= cycleSync && (taken || dataOutEn);
      if (clear) begin
        {latchCount, stateCount, readCount, writeCount, holdErrors} <= '0;
        wordLog <= '0;
      end else begin
        // one latch per sync window, held for the whole cycle
        if (dataOutEn && cycleSync && !taken) begin
          latchCount <= latchCount + 4'h1;
          wordLog <= {wordLog[31:0], dataOut};
        end
        if (dataOutEn && prevEn && dataOut != prevOut)
          holdErrors <= holdErrors + 4'h1;
        if (clockState != prevState && clockState != 3'h0)
          stateCount <= stateCount + 5'h1;
        if (data_bus_in_strobe && !prevIn)
          readCount <= readCount + 4'h1;
        if (!writeStrobe_n && prevWr)
          writeCount <= writeCount + 4'h1;
      end
      // ready changes only on the clock, as if synchronised outside
      if (clockState != 3'h2) begin
        waitCnt <= 2'h0;
        ready <= 1'b1;
      end else if (slowMode && waitCnt != 2'h3) begin
        waitCnt <= waitCnt + 2'h1;
        ready <= 1'b0;
      end else
        ready <= 1'b1;
    end
  end
endmodule : mcss_controller_model

//--- mcss_pkg.sv
// Purpose: shared types and constants for the machine-cycle sequencer
// Assumes: one 10 MHz clock; phase and sync are enables derived from it
// Notes: status bit positions follow the data bus bit order
package mcss_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_INT_ACK = 0;
  localparam int BIT_WRITE_LOW = 1;
  localparam int BIT_STACK = 2;
  localparam int BIT_HALT_ACK = 3;
  localparam int BIT_OUT = 4;
  localparam int BIT_FIRST_FETCH = 5;
  localparam int BIT_INPUT = 6;
  localparam int BIT_MEM_READ = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] STATES_MIN = 3'h3;
  localparam logic [2:0] STATES_FETCH4 = 3'h4;
  localparam logic [2:0] STATES_MAX = 3'h5;
  localparam logic [2:0] CYCLES_MAX = 3'h5;

  // kind of machine cycle
  typedef enum logic [3:0] {
    MC_FETCH4, MC_FETCH5, MC_PC_READ, MC_STACK_READ, MC_STACK_WRITE,
    MC_PTR_READ, MC_PTR_WRITE, MC_DIRECT_WRITE, MC_INTERNAL,
    MC_IO_READ, MC_IO_WRITE, MC_INT_FETCH, MC_HALT
  } mcss_kind_t;

  // instruction class decoded by the surrounding core
  typedef enum logic [3:0] {
    IC_SIMPLE4, IC_REG5, IC_IMM8, IC_JUMP_LXI, IC_CALL, IC_RET_COND,
    IC_DOUBLE_ADD, IC_MEM_INCDEC, IC_STORE_PTR_DIRECT, IC_OUT, IC_IN, IC_HALT
  } mcss_class_t;

  typedef struct packed {
    mcss_class_t cls;
    logic condTrue;
    logic intAck;
  } mcss_instr_t;

  typedef struct packed {
    mcss_kind_t kind;
    logic [2:0] states;
    logic condOnly;
  } mcss_cycle_t;
endpackage : mcss_pkg

//--- mcss_sequencer.sv
// Purpose: split instructions into machine cycles and states, emit status
// Assumes: phi1 and stateTick are one-cycle enables from the core clock
// Notes: status is held from the sync state through the whole cycle
module mcss_sequencer (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // timing enables
  input wire logic phi1,
  input wire logic stateTick,
  input wire logic ready,
  // instruction from the core
  input wire logic instrValid,
  input wire mcss_pkg::mcss_instr_t instr,
  output logic instrReady,
  // bus side
  output logic cycleSync,
  output logic [7:0] dataOut,
  output logic dataOutEn,
  output logic data_bus_in_strobe,
  output logic writeStrobe_n,
  // progress
  output logic [2:0] machineCycle,
  output logic [2:0] clockState,
  output logic busy
);
  typedef enum logic [1:0] {S_IDLE, S_RUN} mcss_state_t;

  logic rstMeta, rstSync, rstN;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  assign rstN = rstSync;

  // cycle table entry: kind, state count, conditional
  function automatic mcss_pkg::mcss_cycle_t cyc(mcss_pkg::mcss_kind_t k,
      logic [2:0] n, logic c);
    cyc = '{kind: k, states: n, condOnly: c};
  endfunction : cyc

  // number of cycles for a class
  function automatic logic [2:0] cycleCount(mcss_pkg::mcss_class_t c);
    unique case (c)
      mcss_pkg::IC_SIMPLE4, mcss_pkg::IC_REG5, mcss_pkg::IC_HALT:
        cycleCount = 3'h1;
      mcss_pkg::IC_IMM8: cycleCount = 3'h2;
      mcss_pkg::IC_JUMP_LXI, mcss_pkg::IC_RET_COND, mcss_pkg::IC_DOUBLE_ADD,
      mcss_pkg::IC_MEM_INCDEC, mcss_pkg::IC_OUT, mcss_pkg::IC_IN:
        cycleCount = 3'h3;
      mcss_pkg::IC_CALL, mcss_pkg::IC_STORE_PTR_DIRECT:
        cycleCount = mcss_pkg::CYCLES_MAX;
      // unused class codes run as a single fetch
      default: cycleCount = 3'h1;
    endcase
  endfunction : cycleCount

  // machine cycle m (0 based) of a class
  function automatic mcss_pkg::mcss_cycle_t cycleOf(
      mcss_pkg::mcss_class_t c, logic [2:0] m);
    mcss_pkg::mcss_cycle_t r;
    r = cyc(mcss_pkg::MC_PC_READ, mcss_pkg::STATES_MIN, 1'b0);
    if (m == 3'h0) begin
      unique case (c)
        mcss_pkg::IC_REG5, mcss_pkg::IC_CALL, mcss_pkg::IC_RET_COND:
          r = cyc(mcss_pkg::MC_FETCH5, mcss_pkg::STATES_MAX, 1'b0);
        default: r = cyc(mcss_pkg::MC_FETCH4, mcss_pkg::STATES_FETCH4, 1'b0);
      endcase
    end else begin
      unique case (c)
        mcss_pkg::IC_DOUBLE_ADD:
          r = cyc(mcss_pkg::MC_INTERNAL, mcss_pkg::STATES_MIN, 1'b0);
        mcss_pkg::IC_CALL:
          r = (m < 3'h3) ? cyc(mcss_pkg::MC_PC_READ, mcss_pkg::STATES_MIN, 1'b0)
                         : cyc(mcss_pkg::MC_STACK_WRITE,
                               mcss_pkg::STATES_MIN, 1'b1);
        mcss_pkg::IC_RET_COND:
          r = cyc(mcss_pkg::MC_STACK_READ, mcss_pkg::STATES_MIN, 1'b1);
        mcss_pkg::IC_MEM_INCDEC:
          r = (m == 3'h1) ? cyc(mcss_pkg::MC_PTR_READ, mcss_pkg::STATES_MIN, 1'b0)
                          : cyc(mcss_pkg::MC_PTR_WRITE,
                                mcss_pkg::STATES_MIN, 1'b0);
        mcss_pkg::IC_STORE_PTR_DIRECT:
          r = (m < 3'h3) ? cyc(mcss_pkg::MC_PC_READ, mcss_pkg::STATES_MIN, 1'b0)
                         : cyc(mcss_pkg::MC_DIRECT_WRITE,
                               mcss_pkg::STATES_MIN, 1'b0);
        mcss_pkg::IC_OUT:
          r = (m == 3'h1) ? cyc(mcss_pkg::MC_PC_READ, mcss_pkg::STATES_MIN, 1'b0)
                          : cyc(mcss_pkg::MC_IO_WRITE,
                                mcss_pkg::STATES_MIN, 1'b0);
        mcss_pkg::IC_IN:
          r = (m == 3'h1) ? cyc(mcss_pkg::MC_PC_READ, mcss_pkg::STATES_MIN, 1'b0)
                          : cyc(mcss_pkg::MC_IO_READ,
                                mcss_pkg::STATES_MIN, 1'b0);
        default:
          r = cyc(mcss_pkg::MC_PC_READ, mcss_pkg::STATES_MIN, 1'b0);
      endcase
    end
    cycleOf = r;
  endfunction : cycleOf

  // status word for a cycle kind
  function automatic logic [7:0] statusOf(mcss_pkg::mcss_kind_t k);
    logic [7:0] s;
    s = 8'h00;
    s[mcss_pkg::BIT_WRITE_LOW] = 1'b1;
    unique case (k)
      mcss_pkg::MC_FETCH4, mcss_pkg::MC_FETCH5: begin
        s[mcss_pkg::BIT_FIRST_FETCH] = 1'b1;
        s[mcss_pkg::BIT_MEM_READ] = 1'b1;
      end
      mcss_pkg::MC_INT_FETCH: begin
        s[mcss_pkg::BIT_FIRST_FETCH] = 1'b1;
        s[mcss_pkg::BIT_INT_ACK] = 1'b1;
      end
      mcss_pkg::MC_PC_READ, mcss_pkg::MC_PTR_READ:
        s[mcss_pkg::BIT_MEM_READ] = 1'b1;
      mcss_pkg::MC_STACK_READ: begin
        s[mcss_pkg::BIT_MEM_READ] = 1'b1;
        s[mcss_pkg::BIT_STACK] = 1'b1;
      end
      mcss_pkg::MC_STACK_WRITE: begin
        s[mcss_pkg::BIT_WRITE_LOW] = 1'b0;
        s[mcss_pkg::BIT_STACK] = 1'b1;
      end
      mcss_pkg::MC_PTR_WRITE, mcss_pkg::MC_DIRECT_WRITE:
        s[mcss_pkg::BIT_WRITE_LOW] = 1'b0;
      mcss_pkg::MC_IO_WRITE: begin
        s[mcss_pkg::BIT_WRITE_LOW] = 1'b0;
        s[mcss_pkg::BIT_OUT] = 1'b1;
      end
      mcss_pkg::MC_IO_READ:
        s[mcss_pkg::BIT_INPUT] = 1'b1;
      mcss_pkg::MC_HALT: begin
        s[mcss_pkg::BIT_HALT_ACK] = 1'b1;
        s[mcss_pkg::BIT_MEM_READ] = 1'b1;
      end
      mcss_pkg::MC_INTERNAL: ;
    endcase
    statusOf = s;
  endfunction : statusOf

  mcss_state_t state;
  mcss_pkg::mcss_instr_t cur;
  logic [2:0] lastCycle;
  mcss_pkg::mcss_cycle_t now;
  mcss_pkg::mcss_kind_t kindNow;
  logic [7:0] statusWord;
  logic lastState, endCycle, skipRest, isRead, isWrite, waitHere, movesByte;
  logic syncSeen, holdSync;
  logic [2:0] next_machineCycle;

  assign now = cycleOf(cur.cls, machineCycle);
  assign kindNow = (machineCycle == 3'h0 && cur.intAck)
                   ? mcss_pkg::MC_INT_FETCH
                   : (cur.cls == mcss_pkg::IC_HALT && machineCycle == 3'h0)
                   ? mcss_pkg::MC_HALT : now.kind;
  assign lastState = (clockState == now.states);
  assign endCycle = (state == S_RUN) && stateTick && lastState;
  // next cycle conditional and condition false ends the instruction
  assign next_machineCycle = machineCycle + 3'h1;
  assign skipRest = cycleOf(cur.cls, next_machineCycle).condOnly
                    && !cur.condTrue;
  assign instrReady = (state == S_IDLE);
  assign busy = (state == S_RUN);
  assign isRead = statusWord[mcss_pkg::BIT_WRITE_LOW]
                  && kindNow != mcss_pkg::MC_INTERNAL;
  assign isWrite = !statusWord[mcss_pkg::BIT_WRITE_LOW];
  // state one is held until a phase-one window has shown the status,
  // otherwise a state one that falls on the wrong phase shows none
  assign holdSync = (clockState == 3'h1) && !syncSeen;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      syncSeen <= 1'b0;
    end else begin
      syncSeen <= (state == S_RUN) && (clockState == 3'h1)
                  && (syncSeen || phi1);
    end
  end
  // one byte moves in each non-internal cycle
  assign movesByte = kindNow != mcss_pkg::MC_INTERNAL;
  // wait states held in the second state while ready is low
  assign waitHere = (clockState == 3'h2) && !ready;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state <= S_IDLE;
      cur <= '0;
      machineCycle <= 3'h0;
      clockState <= 3'h1;
      lastCycle <= 3'h0;
    end else if (state == S_IDLE) begin
      if (instrValid) begin
        state <= S_RUN;
        cur <= instr;
        machineCycle <= 3'h0;
        clockState <= 3'h1;
        lastCycle <= cycleCount(instr.cls) - 3'h1;
      end
    end else if (stateTick && !waitHere && !holdSync) begin
      if (!lastState) begin
        clockState <= clockState + 3'h1;
      end else begin
        clockState <= 3'h1;
        if (machineCycle == lastCycle || skipRest) begin
          state <= S_IDLE;
          machineCycle <= 3'h0;
        end else begin
          machineCycle <= next_machineCycle;
        end
      end
    end
  end

  // status latched at the first state, stable for the whole cycle
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      statusWord <= mcss_pkg::STATUS_RESET;
    end else if (state == S_RUN && clockState == 3'h1) begin
      statusWord <= statusOf(kindNow);
    end
  end

  // sync asserted through the first state; bus output holds status
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      cycleSync <= 1'b0;
      dataOut <= 8'h00;
      dataOutEn <= 1'b0;
      data_bus_in_strobe <= 1'b0;
      writeStrobe_n <= 1'b1;
    end else begin
      cycleSync <= (state == S_RUN) && (clockState == 3'h1);
      dataOut <= statusOf(kindNow);
      dataOutEn <= (state == S_RUN) && (clockState == 3'h1) && phi1;
      data_bus_in_strobe <= busy && movesByte && isRead
                            && (clockState == 3'h2 || clockState == 3'h3);
      writeStrobe_n <= !(busy && movesByte && isWrite
                         && clockState == 3'h3);
    end
  end

  property p_len;
    @(posedge clock) disable iff (!rstN)
      busy |-> (clockState >= 3'h1 && clockState <= 3'h5);
  endproperty
  a_len: assert property (p_len) else $error("bad state number");
  property p_first;
    @(posedge clock) disable iff (!rstN)
      (busy && clockState == 3'h2 && machineCycle != 3'h0)
      |-> !statusWord[mcss_pkg::BIT_FIRST_FETCH];
  endproperty
  a_first: assert property (p_first) else $error("fetch flag late");
  property p_hold;
    @(posedge clock) disable iff (!rstN)
      (busy && clockState == 3'h2) |=> $stable(statusWord) || !busy
        || clockState == 3'h1;
  endproperty
  a_hold: assert property (p_hold) else $error("status moved");
  property p_cyc;
    @(posedge clock) disable iff (!rstN)
      busy |-> machineCycle < mcss_pkg::CYCLES_MAX;
  endproperty
  a_cyc: assert property (p_cyc) else $error("too many cycles");
  property p_write;
    @(posedge clock) disable iff (!rstN)
      !writeStrobe_n |-> !statusWord[mcss_pkg::BIT_WRITE_LOW];
  endproperty
  a_write: assert property (p_write) else $error("write on read");
  property p_out;
    @(posedge clock) disable iff (!rstN)
      (dataOutEn && dataOut[mcss_pkg::BIT_OUT])
      |-> !dataOut[mcss_pkg::BIT_WRITE_LOW];
  endproperty
  a_out: assert property (p_out) else $error("output not a write");
  property p_inp;
    @(posedge clock) disable iff (!rstN)
      (dataOutEn && dataOut[mcss_pkg::BIT_INPUT])
      |-> !dataOut[mcss_pkg::BIT_MEM_READ];
  endproperty
  a_inp: assert property (p_inp) else $error("input with memory read");
  property p_internal;
    @(posedge clock) disable iff (!rstN)
      (busy && cur.cls == mcss_pkg::IC_DOUBLE_ADD && machineCycle != 3'h0)
      |-> !data_bus_in_strobe && writeStrobe_n;
  endproperty
  a_internal: assert property (p_internal) else $error("internal bus use");
  property p_sync_en;
    @(posedge clock) disable iff (!rstN)
      dataOutEn |-> cycleSync;
  endproperty
  a_sync_en: assert property (p_sync_en) else $error("status off sync");
  property p_bus_word;
    @(posedge clock) disable iff (!rstN)
      dataOutEn |-> dataOut == statusWord;
  endproperty
  a_bus_word: assert property (p_bus_word) else $error("bus word differs");
  property p_halt;
    @(posedge clock) disable iff (!rstN)
      (dataOutEn && dataOut[mcss_pkg::BIT_HALT_ACK])
      |-> cur.cls == mcss_pkg::IC_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flag not halt");
  property p_one_way;
    @(posedge clock) disable iff (!rstN)
      data_bus_in_strobe |-> writeStrobe_n;
  endproperty
  a_one_way: assert property (p_one_way) else $error("read and write");
  property p_mem_read;
    @(posedge clock) disable iff (!rstN)
      (dataOutEn && dataOut[mcss_pkg::BIT_MEM_READ])
      |-> dataOut[mcss_pkg::BIT_WRITE_LOW];
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("read marked write");
endmodule : mcss_sequencer
